// >>> irms_top.v
// Interrupt request latching, per-source masks, priority threshold and
// in-service tracking, with an APB register slave.
// Assumes pins come from outside the clock domain; sources 0..4 are the
// external pins, 5 the shared timer, 6 the serial channel.
// Assumes every register is one aligned 32-bit word whose byte address is
// four times its index; unused bits read as zero and ignore writes.
// Assumes int_ack is a one-cycle pulse from the core that takes whichever
// source is winning in that cycle.
// Nothing here forces level mode on a cascaded pin; software must set it.
`timescale 1ns/1ps
`include "irms_defines.vh"

module irms_top #(
  parameter NSRC = 7
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [3:0]  ext_irq_pins_low,
  input  wire        ext_irq_pin_high,
  input  wire        timer_req,
  input  wire        serial_req,
  input  wire        int_ack,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq_out,
  output reg  [2:0]  irq_src,
  output reg  [1:0]  cascade_en,
  output reg  [1:0]  nested_mode
);

  // ****************************************
  // Source identifiers
  // ****************************************
  // Fixed slots of the internal sources in every per-source vector
  localparam SRC_TMR = 5;
  localparam SRC_SER = 6;

  // ****************************************
  // Storage
  // ****************************************
  // Each mask bit exists once, in mask_q; both register views read it,
  // so a write through either one is seen by the other
  reg [4:0]      pin_s1_q;
  reg [4:0]      pin_s2_q;
  reg [4:0]      pin_prev_q;
  reg [4:0]      trig_q;
  reg [1:0]      cas_q;
  reg [1:0]      nest_q;
  reg [NSRC-1:0] mask_q;
  reg [2:0]      pri_q [0:NSRC-1];
  reg [NSRC-1:0] req_q;
  reg [NSRC-1:0] insrv_q;
  reg [2:0]      primask_q;
  reg [NSRC-1:0] raw_req;
  reg [NSRC-1:0] req_d;
  reg [NSRC-1:0] insrv_d;
  reg [2:0]      best_id;
  reg [2:0]      best_pri;
  reg            best_vld;
  reg [2:0]      srv_pri;
  reg            srv_vld;
  reg [2:0]      eoi_id;
  reg            eoi_vld;
  reg [31:0]     rd_d;
  reg            err_d;
  integer        i;

  // Registers sit on aligned words: the word index is the byte address
  // over four, and the two low address bits are not decoded
  wire [11:0] reg_idx = {2'b00, paddr[11:2]};
  wire [4:0]  pin_now = pin_s2_q;
  wire        wr_en   = psel & penable & pwrite & pready;
  wire        rd_en   = psel & penable & ~pwrite & pready;
  wire        poll_rd = rd_en & (reg_idx == `IRMS_OFF_POLL);
  wire        ack     = (int_ack | poll_rd) & best_vld;

  // Map a control offset to its source index; 7 means not a control reg
  // The argument is the word index, never the raw byte address
  function [2:0] ctl_idx;
    input [11:0] a;
    begin
      if (a == `IRMS_OFF_PIN0_CTL) begin
        ctl_idx = 3'd0;
      end else if (a == `IRMS_OFF_PIN1_CTL) begin
        ctl_idx = 3'd1;
      end else if (a == `IRMS_OFF_PIN2_CTL) begin
        ctl_idx = 3'd2;
      end else if (a == `IRMS_OFF_PIN3_CTL) begin
        ctl_idx = 3'd3;
      end else if (a == `IRMS_OFF_PIN4_CTL) begin
        ctl_idx = 3'd4;
      end else if (a == `IRMS_OFF_TMR_CTL) begin
        ctl_idx = 3'd5;
      end else if (a == `IRMS_OFF_SER_CTL) begin
        ctl_idx = 3'd6;
      end else begin
        ctl_idx = 3'd7;
      end
    end
  endfunction

  // Vector type to source: pins 12..15 and 17, timers 8, 18 and 19, serial 20/21
  function [3:0] type_to_src;
    input [4:0] t;
    begin
      case (t)
        5'd12: type_to_src = 4'd0;
        5'd13: type_to_src = 4'd1;
        5'd14: type_to_src = 4'd2;
        5'd15: type_to_src = 4'd3;
        5'd17: type_to_src = 4'd4;
        5'd8, 5'd18, 5'd19: type_to_src = 4'd5;
        5'd20, 5'd21: type_to_src = 4'd6;
        default: type_to_src = 4'd15;
      endcase
    end
  endfunction

  // Decoded once here so every process agrees on the selected register
  wire [2:0] ctl_sel = ctl_idx(reg_idx);
  // Source of a specific end-of-interrupt; 15 marks an unknown type
  wire [3:0] eoi_src = type_to_src(pwdata[4:0]);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Two stages; only the second stage feeds the detectors
  // The edge history resets low, matching the idle pin, so no false
  // edge follows reset
  always @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_q   <= 5'h0_0;
      pin_s2_q   <= 5'h0_0;
      pin_prev_q <= 5'h0_0;
    end else begin
      pin_s1_q   <= {ext_irq_pin_high, ext_irq_pins_low};
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // Raw request per source; internal sources are same-domain levels
  // A stuck-high pin in edge mode asks once; it must fall to re-arm
  always @* begin
    raw_req = {NSRC{1'b0}};
    for (i = 0; i < 5; i = i + 1) begin
      if (trig_q[i]) begin
        raw_req[i] = pin_now[i];
      end else begin
        raw_req[i] = pin_now[i] & ~pin_prev_q[i];
      end
    end
    raw_req[SRC_TMR] = timer_req;
    raw_req[SRC_SER] = serial_req;
  end

  // ****************************************
  // Arbitration
  // ****************************************
  // Highest priority of handlers already running; preemption needs better
  // A lower number is a better priority; with nothing in service srv_vld is low
  always @* begin
    srv_vld = 1'b0;
    srv_pri = 3'h7;
    for (i = 0; i < NSRC; i = i + 1) begin
      if (insrv_q[i] && (!srv_vld || pri_q[i] < srv_pri)) begin
        srv_vld = 1'b1;
        srv_pri = pri_q[i];
      end
    end
  end

  // Lowest index wins ties; nested mode lets a cascade pin re-enter itself
  // Masked or over-threshold requests stay pending but never win, so
  // unmasking later still raises them without a new pin event
  always @* begin
    best_vld = 1'b0;
    best_id  = 3'd0;
    best_pri = 3'h7;
    for (i = 0; i < NSRC; i = i + 1) begin
      if (req_q[i] && !mask_q[i]
          && pri_q[i] <= primask_q
          && (!srv_vld || pri_q[i] < srv_pri
              || (i < 2 && nest_q[i] && insrv_q[i]))
          && (!best_vld || pri_q[i] < best_pri)) begin
        best_vld = 1'b1;
        best_id  = i[2:0];
        best_pri = pri_q[i];
      end
    end
  end

  // End-of-interrupt decode: nonspecific clears highest priority in service
  // Unknown vector types are ignored; all timer types share one bit
  always @* begin
    eoi_vld = 1'b0;
    eoi_id  = 3'd0;
    if (wr_en && reg_idx == `IRMS_OFF_EOI) begin
      if (pwdata[`IRMS_EOI_NSPEC_BIT]) begin
        for (i = NSRC - 1; i >= 0; i = i - 1) begin
          if (insrv_q[i] && pri_q[i] <= srv_pri) begin
            eoi_vld = 1'b1;
            eoi_id  = i[2:0];
          end
        end
      end else if (eoi_src != 4'd15) begin
        eoi_vld = 1'b1;
        eoi_id  = eoi_src[2:0];
      end
    end
  end

  // Pending and in-service next state; the ack clear wins for its own source
  // A level pin still high sets its bit again one cycle later, and that bit
  // stays pending even if the pin falls before the end-of-interrupt command; only edge
  // mode drops a pending bit when the pin falls early
  always @* begin
    req_d   = req_q;
    insrv_d = insrv_q;
    for (i = 0; i < NSRC; i = i + 1) begin
      if (i < 5 && !trig_q[i] && !pin_now[i]) begin
        req_d[i] = 1'b0;       // Early drop loses the request
      end
      if (ack && best_id == i[2:0]) begin
        req_d[i]   = 1'b0;
        insrv_d[i] = 1'b1;
      end else if (eoi_vld && eoi_id == i[2:0]) begin
        insrv_d[i] = 1'b0;
      end
      if (raw_req[i] && !(ack && best_id == i[2:0])) begin
        req_d[i] = 1'b1;       // Masked or not
      end
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  // Writes land at the edge where the access phase meets pready, the same
  // edge at which the bus master releases; reserved fields are dropped
  always @(posedge clk) begin
    if (!rst_n) begin
      trig_q    <= 5'h0_0;
      cas_q     <= 2'h0;
      nest_q    <= 2'h0;
      mask_q    <= {NSRC{`IRMS_RST_MASK}};
      primask_q <= `IRMS_RST_PRIMASK;
      req_q     <= {NSRC{1'b0}};
      insrv_q   <= {NSRC{1'b0}};
      for (i = 0; i < NSRC; i = i + 1) begin
        pri_q[i] <= `IRMS_RST_PRI;
      end
    end else begin
      req_q   <= req_d;
      insrv_q <= insrv_d;
      if (wr_en && ctl_sel != 3'd7) begin
        pri_q[ctl_sel]  <= pwdata[`IRMS_CTL_PRI_LSB +: 3];
        mask_q[ctl_sel] <= pwdata[`IRMS_CTL_MASK_BIT];
        if (ctl_sel < 3'd5) begin
          trig_q[ctl_sel] <= pwdata[`IRMS_CTL_TRIG_BIT];
        end
        if (ctl_sel < 3'd2) begin
          cas_q[ctl_sel[0]]  <= pwdata[`IRMS_CTL_CAS_BIT];
          nest_q[ctl_sel[0]] <= pwdata[`IRMS_CTL_NEST_BIT];
        end
      end else if (wr_en && reg_idx == `IRMS_OFF_MASK) begin
        mask_q <= pwdata[NSRC-1:0];
      end else if (wr_en && reg_idx == `IRMS_OFF_PRIMASK) begin
        primask_q <= pwdata[2:0];
      end
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  // Register read data so prdata comes from a flop; one wait state
  // The decode uses the settled address of the first access cycle; the
  // flopped word then stands for the single cycle that pready is high
  always @* begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (ctl_sel != 3'd7) begin
      rd_d[`IRMS_CTL_PRI_LSB +: 3]  = pri_q[ctl_sel];
      rd_d[`IRMS_CTL_MASK_BIT]      = mask_q[ctl_sel];
      if (ctl_sel < 3'd5) begin
        rd_d[`IRMS_CTL_TRIG_BIT] = trig_q[ctl_sel];
      end
      if (ctl_sel < 3'd2) begin
        rd_d[`IRMS_CTL_CAS_BIT]  = cas_q[ctl_sel[0]];
        rd_d[`IRMS_CTL_NEST_BIT] = nest_q[ctl_sel[0]];
      end
    end else if (reg_idx == `IRMS_OFF_REQ) begin
      rd_d[NSRC-1:0] = req_q;
    end else if (reg_idx == `IRMS_OFF_HANDLER_ACTIVE_FLAGS) begin
      rd_d[NSRC-1:0] = insrv_q;
    end else if (reg_idx == `IRMS_OFF_MASK) begin
      rd_d[NSRC-1:0] = mask_q;
    end else if (reg_idx == `IRMS_OFF_PRIMASK) begin
      rd_d[2:0] = primask_q;
    end else if (reg_idx == `IRMS_OFF_POLL) begin
      rd_d[31]  = best_vld;
      rd_d[2:0] = best_id;
    end else if (reg_idx == `IRMS_OFF_EOI) begin
      rd_d = 32'h0000_0000;
    end else begin
      err_d = 1'b1;
    end
  end

  // Ready toggles in the first access cycle; one-shot so requests never merge
  // Two cycles per access is the price of flopped outputs; back-to-back
  // transfers still work because pready always falls after one cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & err_d;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_d : 32'h0000_0000;
    end
  end

  // ****************************************
  // Outputs to the core
  // ****************************************
  // All outputs are flopped, so irq_out lags the pending bit by one cycle
  // and drops at the same edge that takes the acknowledge
  // Cascade controls go to the acknowledge logic; software keeps
  // such pins in level mode
  always @(posedge clk) begin
    if (!rst_n) begin
      irq_out     <= 1'b0;
      irq_src     <= 3'd0;
      cascade_en  <= 2'h0;
      nested_mode <= 2'h0;
    end else begin
      irq_out     <= best_vld & ~ack;
      irq_src     <= best_id;
      cascade_en  <= cas_q;
      nested_mode <= nest_q;
    end
  end

endmodule

// >>> irms_defines.vh
// Constants for the interrupt request, mask and in-service block.
// Assumes a 32-bit APB register bus; offsets are word indices and the
// byte address of each register is four times its index.
`ifndef IRMS_DEFINES_VH
`define IRMS_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define IRMS_OFF_TMR_CTL   12'h0_012
`define IRMS_OFF_SER_CTL   12'h0_014
`define IRMS_OFF_PIN4_CTL  12'h0_016
`define IRMS_OFF_PIN0_CTL  12'h0_018
`define IRMS_OFF_PIN1_CTL  12'h0_01a
`define IRMS_OFF_PIN2_CTL  12'h0_01c
`define IRMS_OFF_PIN3_CTL  12'h0_01e
`define IRMS_OFF_REQ       12'h0_00e
`define IRMS_OFF_HANDLER_ACTIVE_FLAGS    12'h0_00c
`define IRMS_OFF_PRIMASK   12'h0_00a
`define IRMS_OFF_MASK      12'h0_008
`define IRMS_OFF_POLL      12'h0_004
`define IRMS_OFF_EOI       12'h0_002

// ****************************************
// Control register fields
// ****************************************
`define IRMS_CTL_PRI_LSB   0
`define IRMS_CTL_MASK_BIT  3
`define IRMS_CTL_TRIG_BIT  4
`define IRMS_CTL_CAS_BIT   5
`define IRMS_CTL_NEST_BIT  6
`define IRMS_EOI_NSPEC_BIT 15

// ****************************************
// Reset values
// ****************************************
`define IRMS_RST_PRI       3'h7
`define IRMS_RST_PRIMASK   3'h7
`define IRMS_RST_MASK      1'b1

`endif

// >>> irms_chk.sv
// Checker for the interrupt request, mask and in-service block.
// Assumes it is bound to irms_top and sees only that module's ports.
`timescale 1ns/1ps
module irms_chk #(
  parameter NSRC = 7
) (
  input wire        clk,
  input wire        rst_n,
  input wire [3:0]  ext_irq_pins_low,
  input wire        ext_irq_pin_high,
  input wire        timer_req,
  input wire        serial_req,
  input wire        int_ack,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        irq_out,
  input wire [2:0]  irq_src,
  input wire [1:0]  cascade_en,
  input wire [1:0]  nested_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Any request line; a raised irq must trace back to one or to a write
  wire req_any = (|ext_irq_pins_low) | ext_irq_pin_high | timer_req | serial_req;
  // ****************************************
  // Assertions
  // ****************************************
  a_ready_one_wait: assert property (
      psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response without ready or with data");
  a_ctl_reset_zero: assert property (
      $rose(rst_n) |-> cascade_en == 2'b00 && nested_mode == 2'b00)
    else $error("cascade or nested bits not zero after reset");
  a_cas_by_write: assert property (
      $changed(cascade_en) |-> $past(pwrite && pready) || $past(pwrite && pready, 2))
    else $error("cascade bits changed without a write");
  a_nest_by_write: assert property (
      $changed(nested_mode) |-> $past(pwrite && pready) || $past(pwrite && pready, 2))
    else $error("nested bits changed without a write");
  a_ack_takes_src: assert property (
      int_ack && irq_out && nested_mode == 2'b00 |=> !irq_out || irq_src != $past(irq_src))
    else $error("acknowledged source still offered");
  a_irq_has_cause: assert property (
      $rose(irq_out) |-> $past(req_any, 2) || $past(req_any, 3) || $past(req_any, 4)
        || $past(pready) || $past(pready, 2))
    else $error("irq raised without request or write");
endmodule

bind irms_top irms_chk #(.NSRC(NSRC)) u_chk (.clk(clk), .rst_n(rst_n),
  .ext_irq_pins_low(ext_irq_pins_low), .ext_irq_pin_high(ext_irq_pin_high),
  .timer_req(timer_req), .serial_req(serial_req), .int_ack(int_ack), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_out(irq_out), .irq_src(irq_src), .cascade_en(cascade_en), .nested_mode(nested_mode));

// >>> irms_src_model.sv
// External interrupt requesters on pins 0..4.
// Assumes raise and drop are one-cycle pulses from the bench.
`timescale 1ns/1ps
module irms_src_model (
  input wire       clk,
  input wire       rst_n,
  input wire [4:0] raise,
  input wire [4:0] drop,
  input wire [4:0] keep,
  input wire       int_ack,
  input wire [2:0] irq_src,
  output reg [4:0] pins
);
  // Hold a pin until its acknowledge is sampled, then release it so the
  // edge detector re-arms; keep models a level source that stays high
  always @(posedge clk) begin
    if (!rst_n) pins <= 5'h00;
    else pins <= (pins | raise) & ~drop
                 & ~({5{int_ack}} & ~keep & (5'h01 << irq_src));
  end
endmodule

// >>> irms_top_tb.sv
// Self-checking bench for irms_top: APB register access and pin traffic.
// Assumes irms_src_model drives the pins and the checker is bound.
`timescale 1ns/1ps
`include "irms_defines.vh"
module irms_top_tb;
  logic        clk, rst_n, int_ack, psel, penable, pwrite, timer_req, serial_req, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [4:0]  raise, drop, keep;
  wire  [4:0]  pins;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq_out;
  wire  [2:0]  irq_src;
  wire  [1:0]  cascade_en, nested_mode;
  int          err_total = 0, checks_done = 0, cyc = 0;
  irms_top dut (.clk(clk), .rst_n(rst_n), .ext_irq_pins_low(pins[3:0]),
    .ext_irq_pin_high(pins[4]), .timer_req(timer_req), .serial_req(serial_req),
    .int_ack(int_ack), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_out(irq_out),
    .irq_src(irq_src), .cascade_en(cascade_en), .nested_mode(nested_mode));
  irms_src_model src (.clk(clk), .rst_n(rst_n), .raise(raise), .drop(drop), .keep(keep),
    .int_ack(int_ack), .irq_src(irq_src), .pins(pins));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // One transfer, then an idle cycle so back-to-back calls never clash
  // a is the register's word index; the byte address is four times it
  task automatic apb(bit w, logic [11:0] a, logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= {a[9:0], 2'b00}; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h0000_0001, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(string nm, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  task automatic pin(logic [4:0] up, logic [4:0] dn);
    raise <= up; drop <= dn;
    @(posedge clk);
    raise <= 5'h00; drop <= 5'h00;
  endtask
  task automatic ack;
    int_ack <= 1'b1;
    @(posedge clk);
    int_ack <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Bounded wait: the pin synchroniser makes the latency a few cycles
  task automatic wirq;
    int n;
    n = 0;
    while (irq_out !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    chk("irq_out", 32'h0000_0001, irq_out);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rdc("pin0_ctl", `IRMS_OFF_PIN0_CTL, 32'h0000_000f);
    rdc("pin1_ctl", `IRMS_OFF_PIN1_CTL, 32'h0000_000f);
    rdc("primask", `IRMS_OFF_PRIMASK, 32'h0000_0007);
    rdc("mask", `IRMS_OFF_MASK, 32'h0000_007f);
    rdc("handler_active_flags", `IRMS_OFF_HANDLER_ACTIVE_FLAGS, 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, {31'h0000_0000, er});
    $display("test reset done");
  endtask
  task automatic t_edge;
    apb(1'b1, `IRMS_OFF_PIN0_CTL, 32'h0000_0007);
    raise <= 5'h05; timer_req <= 1'b1; serial_req <= 1'b1;
    @(posedge clk);
    raise <= 5'h00; timer_req <= 1'b0; serial_req <= 1'b0;
    wirq;
    chk("irq_src", 32'h0000_0000, irq_src);
    rdc("req", `IRMS_OFF_REQ, 32'h0000_0065);
    ack;
    rdc("req_ack", `IRMS_OFF_REQ, 32'h0000_0064);
    rdc("handler_active_flags_ack", `IRMS_OFF_HANDLER_ACTIVE_FLAGS, 32'h0000_0001);
    chk("irq_masked", 32'h0000_0000, irq_out);
    pin(5'h00, 5'h04);
    repeat (3) @(posedge clk);
    rdc("req_early_drop", `IRMS_OFF_REQ, 32'h0000_0060);
    apb(1'b1, `IRMS_OFF_EOI, 32'h0000_000c);
    rdc("handler_active_flags_eoi", `IRMS_OFF_HANDLER_ACTIVE_FLAGS, 32'h0000_0000);
    pin(5'h01, 5'h00);
    wirq;
    ack;
    apb(1'b1, `IRMS_OFF_EOI, 32'h0000_8000);
    rdc("handler_active_flags_nspec", `IRMS_OFF_HANDLER_ACTIVE_FLAGS, 32'h0000_0000);
    $display("test edge done");
  endtask
  task automatic t_mask;
    apb(1'b1, `IRMS_OFF_MASK, 32'h0000_007f);
    rdc("pin0_shared", `IRMS_OFF_PIN0_CTL, 32'h0000_000f);
    apb(1'b1, `IRMS_OFF_PIN1_CTL, 32'h0000_0075);
    rdc("mask_shared", `IRMS_OFF_MASK, 32'h0000_007d);
    rdc("pin1_ctl", `IRMS_OFF_PIN1_CTL, 32'h0000_0075);
    chk("cascade_en", 32'h0000_0002, cascade_en);
    chk("nested_mode", 32'h0000_0002, nested_mode);
    $display("test mask done");
  endtask
  task automatic t_thresh;
    apb(1'b1, `IRMS_OFF_PRIMASK, 32'h0000_0004);
    keep <= 5'h02;
    pin(5'h02, 5'h00);
    repeat (8) @(posedge clk);
    chk("irq_blocked", 32'h0000_0000, irq_out);
    apb(1'b1, `IRMS_OFF_PRIMASK, 32'h0000_0005);
    wirq;
    chk("irq_src", 32'h0000_0001, irq_src);
    ack;
    rdc("req_level", `IRMS_OFF_REQ, 32'h0000_0062);
    rdc("handler_active_flags_pin1", `IRMS_OFF_HANDLER_ACTIVE_FLAGS, 32'h0000_0002);
    chk("irq_nested", 32'h0000_0001, irq_out);
    keep <= 5'h00;
    pin(5'h00, 5'h02);
    apb(1'b1, `IRMS_OFF_EOI, 32'h0000_000d);
    rdc("handler_active_flags_clear", `IRMS_OFF_HANDLER_ACTIVE_FLAGS, 32'h0000_0000);
    rdc("poll", `IRMS_OFF_POLL, 32'h8000_0001);
    rdc("req_poll", `IRMS_OFF_REQ, 32'h0000_0060);
    rdc("handler_active_flags_poll", `IRMS_OFF_HANDLER_ACTIVE_FLAGS, 32'h0000_0002);
    apb(1'b1, `IRMS_OFF_EOI, 32'h0000_8000);
    rdc("handler_active_flags_done", `IRMS_OFF_HANDLER_ACTIVE_FLAGS, 32'h0000_0000);
    $display("test thresh done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // A hang is cut short well above the fewer than two hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; int_ack = 1'b0; timer_req = 1'b0; serial_req = 1'b0;
    raise = 5'h00; drop = 5'h00; keep = 5'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_edge;
    t_mask;
    t_thresh;
    print_verdict;
  end
endmodule
